// file: shared/flash_seq_defines.vh
// Register map, field positions, codes and timing counts of the sequencer
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH
// Register addresses on the bus
`define ADDR_DIV       16'h0000
`define ADDR_STAT      16'h0001
`define ADDR_CMD       16'h0002
`define ADDR_PROT      16'h0003
// Array window: top 4 KB of the address space
`define ARRAY_HI       4'hF
// Divider register fields
`define DIV_LOADED     7
`define DIV_PRE8       6
// Status register fields
`define ST_CBEF        7
`define ST_CCF         6
`define ST_PVIOL       5
`define ST_ACCERR      4
`define ST_BLANK       2
// Protection register fields
`define PROT_DIS       0
`define PROT_RST       8'hFF
// Command codes
`define CMD_VERIFY     8'h05
`define CMD_PROG       8'h20
`define CMD_BURST      8'h25
`define CMD_SECTOR     8'h40
`define CMD_MASS       8'h41
// Array geometry
`define ARR_LAST       12'hFFF
`define ARR_SIZE       13'h1000
`define PAGE_SIZE      13'h0200
`define ERASED         8'hFF
// Timing in timing-clock periods; prescaler last count in system clocks
`define PROG_TICKS     15'h0009
`define BURST_TICKS    15'h0004
`define PRE8_LAST      3'h7
`endif

// file: design/flash_command_sequencer.v
// Command sequencer for a 4 KB program flash array
`timescale 1ns/1ps
// Notes on behaviour
// - Only first accepted divider write after reset counts
// - Divider write blocked while access error set
// - Pulses timed in whole timing-clock periods
// - Byte program 9 periods, burst byte 4
// - Page erase 4000, mass erase 20000 periods
// - Erase verify: array write, 0x05, launch
// - Blank only if all erased; stop early
// - Verify takes one cycle per address plus few
// - Program latched data at latched address
// - Protected program target flags violation, no start
// - Completion flag sets when program finishes
// - Two-stage burst queue accepts next sequence
// - Queued burst 0x25 ignores address, increments internally
// - High voltage held between queued burst bytes
// - Burst continues rows, stops at array end
// - Queued burst suppresses completion, continues on
// - Protected burst data flags violation, refused
// - Mass erase 0x41 only without protection
// - Sector erase 0x40 erases addressed sector
// - Array is 4096 bytes, eight 512-byte pages
// - Sector erase ignores address bits 8:0, data
// - Protocol breach sets access error, blocks commands
// - Unknown command code sets access error
// - Array write when busy or undivided errors
`include "flash_seq_defines.vh"

module flash_command_sequencer #(
  parameter [14:0] PAGE_ERASE_TICKS  = 15'd4000,
  parameter [14:0] MASS_ERASE_TICKS  = 15'd20000,
  parameter [14:0] BURST_START_TICKS = 15'd3,
  parameter [14:0] BURST_END_TICKS   = 15'd2
) (
  // Clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  // Register and array bus
  input  wire [15:0] addr_i,
  input  wire [7:0]  wr_data_i,
  input  wire        wr_en_i,
  input  wire        rd_en_i,
  output wire [7:0]  rd_data_o,
  // Status towards the array
  output wire        hv_enable_o,
  output wire        cmd_complete_o
);

  // Sequence states
  localparam [1:0] S_EMPTY = 2'd0;
  localparam [1:0] S_ADDR  = 2'd1;
  localparam [1:0] S_CMD   = 2'd2;
  // Execution states
  localparam [2:0] X_IDLE   = 3'd0;
  localparam [2:0] X_VERIFY = 3'd1;
  localparam [2:0] X_PROG   = 3'd2;
  localparam [2:0] X_ERASE  = 3'd3;
  localparam [2:0] X_BURST  = 3'd4;

  reg [7:0]  mem [0:4095];
  reg [7:0]  div_q;
  reg [7:0]  prot_q;
  reg [7:0]  cmd_q;
  reg [11:0] lat_addr_q;
  reg [7:0]  lat_data_q;
  reg [1:0]  s_state_q;
  reg [2:0]  x_state_q;
  reg        cbef_q;
  reg        ccf_q;
  reg        pviol_q;
  reg        accerr_q;
  reg        blank_q;
  reg [2:0]  pre_q;
  reg [5:0]  dcnt_q;
  reg        tick_q;
  reg [14:0] tcnt_q;
  reg [12:0] walk_q;
  reg [12:0] er_len_q;
  reg [11:0] er_base_q;
  reg [11:0] cur_addr_q;
  reg [7:0]  cur_data_q;
  reg        pend_valid_q;
  reg [7:0]  pend_data_q;
  reg        tail_q;
  reg        hv_q;
  reg [7:0]  rd_data_q;
  // True when a byte of the array lies above the unprotected limit
  function prot_hit;
    input [11:0] off;
    input [7:0]  prot;
    begin
      prot_hit = !prot[`PROT_DIS] &&
                 ({`ARRAY_HI, off} > {prot[7:1], 9'h1FF});
    end
  endfunction
  function code_ok;
    input [7:0] c;
    begin
      code_ok = (c == `CMD_VERIFY) || (c == `CMD_PROG) ||
                (c == `CMD_BURST) || (c == `CMD_SECTOR) ||
                (c == `CMD_MASS);
    end
  endfunction
  // Bus decode
  wire arr_hit = (addr_i[15:12] == `ARRAY_HI);
  wire w_arr   = wr_en_i && arr_hit;
  wire w_div   = wr_en_i && (addr_i == `ADDR_DIV);
  wire w_stat  = wr_en_i && (addr_i == `ADDR_STAT);
  wire w_cmd   = wr_en_i && (addr_i == `ADDR_CMD);
  wire w_prot  = wr_en_i && (addr_i == `ADDR_PROT);

  wire        x_idle    = (x_state_q == X_IDLE);
  wire        t_zero    = (tcnt_q == 15'h0000);
  wire [11:0] next_addr = cur_addr_q + 12'h001;
  wire        launch    = w_stat && wr_data_i[`ST_CBEF] &&
                          (s_state_q == S_CMD) && !accerr_q;
  wire        queue_burst = (x_state_q == X_BURST) &&
                            (cmd_q == `CMD_BURST);

  // Protocol breaches
  wire e_arr = w_arr && !accerr_q &&
               (!div_q[`DIV_LOADED] || !cbef_q ||
                (s_state_q != S_EMPTY));
  wire e_cmd = w_cmd && !accerr_q &&
               ((s_state_q != S_ADDR) || !code_ok(wr_data_i));
  wire e_ctl = ((w_div || w_prot) && (s_state_q != S_EMPTY)) ||
               (w_stat && (s_state_q == S_ADDR)) ||
               (w_stat && (s_state_q == S_CMD) &&
                !wr_data_i[`ST_CBEF]);
  wire e_busy = launch && !x_idle && !queue_burst;
  wire e_edge = launch && queue_burst &&
                (cur_addr_q == `ARR_LAST);
  wire acc_set = e_arr || e_cmd || e_ctl || e_busy || e_edge;

  // Protection check of the buffered command
  reg viol;
  always @* begin
    viol = 1'b0;
    if (queue_burst) begin
      viol = prot_hit(next_addr, prot_q);
    end else begin
      case (cmd_q)
        `CMD_PROG:   viol = prot_hit(lat_addr_q, prot_q);
        `CMD_BURST:  viol = prot_hit(lat_addr_q, prot_q);
        `CMD_SECTOR: viol = prot_hit({lat_addr_q[11:9], 9'h000},
                                     prot_q);
        `CMD_MASS:   viol = !prot_q[`PROT_DIS];
        default:     viol = 1'b0;
      endcase
    end
  end
  wire go     = launch && !e_busy && !e_edge && !viol;
  wire v_fail = launch && !e_busy && !e_edge && viol;

  // Array write port
  reg        mem_we;
  reg [11:0] mem_wa;
  reg [7:0]  mem_wd;
  always @* begin
    mem_we = 1'b0;
    mem_wa = cur_addr_q;
    mem_wd = cur_data_q;
    if (x_state_q == X_PROG && t_zero) begin
      mem_we = 1'b1;
    end else if (x_state_q == X_BURST && t_zero && !tail_q) begin
      mem_we = 1'b1;
    end else if (x_state_q == X_ERASE && walk_q != er_len_q) begin
      mem_we = 1'b1;
      mem_wa = er_base_q + walk_q[11:0];
      mem_wd = `ERASED;
    end
  end

  always @(posedge sys_clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  wire verify_bad = (mem[walk_q[11:0]] != `ERASED);

  // Timing clock divider
  wire pre_end = !div_q[`DIV_PRE8] || (pre_q == `PRE8_LAST);
  wire div_end = pre_end && (dcnt_q == div_q[5:0]);
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_q  <= 3'h0;
      dcnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (!div_q[`DIV_LOADED]) begin
      pre_q  <= 3'h0;
      dcnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= div_q[`DIV_PRE8] ? pre_q + 3'h1 : 3'h0;
      dcnt_q <= div_end ? 6'h00 : (pre_end ? dcnt_q + 6'h01 : dcnt_q);
      tick_q <= div_end;
    end
  end

  // Sequencer, flags and execution
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q        <= 8'h00;
      prot_q       <= `PROT_RST;
      cmd_q        <= 8'h00;
      lat_addr_q   <= 12'h000;
      lat_data_q   <= 8'h00;
      s_state_q    <= S_EMPTY;
      x_state_q    <= X_IDLE;
      cbef_q       <= 1'b1;
      ccf_q        <= 1'b1;
      pviol_q      <= 1'b0;
      accerr_q     <= 1'b0;
      blank_q      <= 1'b0;
      tcnt_q       <= 15'h0000;
      walk_q       <= 13'h0000;
      er_len_q     <= 13'h0000;
      er_base_q    <= 12'h000;
      cur_addr_q   <= 12'h000;
      cur_data_q   <= 8'h00;
      pend_valid_q <= 1'b0;
      pend_data_q  <= 8'h00;
      tail_q       <= 1'b0;
      hv_q         <= 1'b0;
    end else begin
      // Error flags: a new event wins over a software clear
      if (acc_set) begin
        accerr_q <= 1'b1;
      end else if (w_stat && wr_data_i[`ST_ACCERR]) begin
        accerr_q <= 1'b0;
      end
      if (v_fail) begin
        pviol_q <= 1'b1;
      end else if (w_stat && wr_data_i[`ST_PVIOL]) begin
        pviol_q <= 1'b0;
      end
      // Configuration registers
      if (w_div && !div_q[`DIV_LOADED] && !accerr_q &&
          (s_state_q == S_EMPTY)) begin
        div_q <= {1'b1, wr_data_i[6:0]};
      end
      if (w_prot && (s_state_q == S_EMPTY)) begin
        prot_q <= wr_data_i;
      end
      // Command write sequence
      if (acc_set || v_fail) begin
        s_state_q <= S_EMPTY;
      end else if (w_arr && !accerr_q) begin
        lat_addr_q <= addr_i[11:0];
        lat_data_q <= wr_data_i;
        s_state_q  <= S_ADDR;
      end else if (w_cmd && !accerr_q) begin
        cmd_q     <= wr_data_i;
        s_state_q <= S_CMD;
      end else if (go) begin
        s_state_q <= S_EMPTY;
      end
      // Launch
      if (go) begin
        cbef_q <= 1'b0;
        if (queue_burst) begin
          pend_valid_q <= 1'b1;
          pend_data_q  <= lat_data_q;
        end else begin
          ccf_q      <= 1'b0;
          blank_q    <= 1'b0;
          cur_addr_q <= lat_addr_q;
          cur_data_q <= lat_data_q;
          walk_q     <= 13'h0000;
          tail_q     <= 1'b0;
          case (cmd_q)
            `CMD_VERIFY: begin
              x_state_q <= X_VERIFY;
            end
            `CMD_PROG: begin
              x_state_q <= X_PROG;
              tcnt_q    <= `PROG_TICKS;
              hv_q      <= 1'b1;
            end
            `CMD_BURST: begin
              x_state_q <= X_BURST;
              tcnt_q    <= BURST_START_TICKS + `BURST_TICKS;
              hv_q      <= 1'b1;
            end
            `CMD_SECTOR: begin
              x_state_q <= X_ERASE;
              er_base_q <= {lat_addr_q[11:9], 9'h000};
              er_len_q  <= `PAGE_SIZE;
              tcnt_q    <= PAGE_ERASE_TICKS;
              hv_q      <= 1'b1;
            end
            default: begin
              x_state_q <= X_ERASE;
              er_base_q <= 12'h000;
              er_len_q  <= `ARR_SIZE;
              tcnt_q    <= MASS_ERASE_TICKS;
              hv_q      <= 1'b1;
            end
          endcase
        end
      end else begin
        if (tick_q && !t_zero) begin
          tcnt_q <= tcnt_q - 15'h0001;
        end
        case (x_state_q)
          X_VERIFY: begin
            if (verify_bad) begin
              x_state_q <= X_IDLE;
              ccf_q     <= 1'b1;
              cbef_q    <= 1'b1;
            end else if (walk_q[11:0] == `ARR_LAST) begin
              blank_q   <= 1'b1;
              x_state_q <= X_IDLE;
              ccf_q     <= 1'b1;
              cbef_q    <= 1'b1;
            end else begin
              walk_q <= walk_q + 13'h0001;
            end
          end
          X_PROG: begin
            if (t_zero) begin
              x_state_q <= X_IDLE;
              ccf_q     <= 1'b1;
              cbef_q    <= 1'b1;
              hv_q      <= 1'b0;
            end
          end
          X_ERASE: begin
            if (walk_q != er_len_q) begin
              walk_q <= walk_q + 13'h0001;
            end else if (t_zero) begin
              x_state_q <= X_IDLE;
              ccf_q     <= 1'b1;
              cbef_q    <= 1'b1;
              hv_q      <= 1'b0;
            end
          end
          X_BURST: begin
            if (t_zero && !tail_q) begin
              if (pend_valid_q) begin
                cur_addr_q   <= next_addr;
                cur_data_q   <= pend_data_q;
                pend_valid_q <= 1'b0;
                cbef_q       <= 1'b1;
                tcnt_q       <= `BURST_TICKS;
              end else begin
                tail_q <= 1'b1;
                tcnt_q <= BURST_END_TICKS;
                cbef_q <= 1'b0;
              end
            end else if (t_zero && tail_q) begin
              x_state_q <= X_IDLE;
              ccf_q     <= 1'b1;
              cbef_q    <= 1'b1;
              hv_q      <= 1'b0;
            end else if (!tail_q && !pend_valid_q) begin
              cbef_q <= 1'b1;
            end
          end
          default: begin
            x_state_q <= X_IDLE;
          end
        endcase
      end
    end
  end

  // Register read path
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_q <= 8'h00;
    end else if (rd_en_i) begin
      if (arr_hit) begin
        rd_data_q <= mem[addr_i[11:0]];
      end else begin
        case (addr_i)
          `ADDR_DIV:  rd_data_q <= div_q;
          `ADDR_STAT: rd_data_q <= {cbef_q, ccf_q, pviol_q, accerr_q,
                                    1'b0, blank_q, 2'b00};
          `ADDR_CMD:  rd_data_q <= cmd_q;
          `ADDR_PROT: rd_data_q <= prot_q;
          default:    rd_data_q <= 8'h00;
        endcase
      end
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  assign rd_data_o      = rd_data_q;
  assign hv_enable_o    = hv_q;
  assign cmd_complete_o = ccf_q;

endmodule

// file: test/host_bus_model.sv
// Host bus master that drives register and array cycles
`timescale 1ns/1ps
`include "flash_seq_defines.vh"
module host_bus_model (
  // Clock
  input  wire        sys_clk_i,
  // Bus towards the sequencer
  output reg  [15:0] addr_o    = 16'h0000,
  output reg  [7:0]  wr_data_o = 8'h00,
  output reg         wr_en_o   = 1'b0,
  output reg         rd_en_o   = 1'b0,
  input  wire [7:0]  rd_data_i
);
  // Prescale 8, divide 25: 200 clocks per tick, 200 kHz at 40 MHz
  localparam [7:0] DIV_SET = 8'h58;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_en_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_en_o <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_en_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_en_o <= 1'b0;
    #1;
    d = rd_data_i;
  endtask
  // Array write, command code, launch
  task automatic seq(input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] c);
    wr(a, d);
    wr(`ADDR_CMD, c);
    wr(`ADDR_STAT, 8'h80);
  endtask
endmodule

// file: test/flash_seq_checker_asserts.sv
// Port checks for the flash command sequencer
`timescale 1ns/1ps
`include "flash_seq_defines.vh"
module flash_seq_checker (
  // Clock and reset
  input wire        sys_clk_i,
  input wire        rst_n_i,
  // Bus
  input wire [15:0] addr_i,
  input wire [7:0]  wr_data_i,
  input wire        wr_en_i,
  input wire        rd_en_i,
  input wire [7:0]  rd_data_o,
  // Status
  input wire        hv_enable_o,
  input wire        cmd_complete_o
);
  wire launch = wr_en_i && addr_i == `ADDR_STAT && wr_data_i[`ST_CBEF];
  wire unmapped = addr_i > `ADDR_PROT && addr_i[15:12] != `ARRAY_HI;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_rd_idle;
    !$past(rd_en_i) |-> rd_data_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  property p_rd_unmapped;
    rd_en_i && unmapped |=> rd_data_o == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  property p_hv_excl;
    hv_enable_o |-> !cmd_complete_o;
  endproperty
  a_hv_excl: assert property (p_hv_excl)
    else $error("high voltage while complete");
  property p_fall_launch;
    $fell(cmd_complete_o) |-> $past(launch);
  endproperty
  a_fall_launch: assert property (p_fall_launch)
    else $error("complete cleared without launch");
  property p_reset_idle;
    !$past(rst_n_i) |-> cmd_complete_o && !hv_enable_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("not idle after reset");
  property p_hv_end;
    $fell(hv_enable_o) |-> ##[0:500] cmd_complete_o;
  endproperty
  a_hv_end: assert property (p_hv_end)
    else $error("no completion after pulse");
  property p_rd_quiet;
    rd_en_i && cmd_complete_o |=> cmd_complete_o;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read disturbed completion");
  property p_hv_rise;
    $rose(hv_enable_o) |-> $past(launch) || !$past(cmd_complete_o);
  endproperty
  a_hv_rise: assert property (p_hv_rise)
    else $error("high voltage without launch");
endmodule

bind flash_command_sequencer flash_seq_checker u_chk (
  .sys_clk_i      (sys_clk_i),
  .rst_n_i        (rst_n_i),
  .addr_i         (addr_i),
  .wr_data_i      (wr_data_i),
  .wr_en_i        (wr_en_i),
  .rd_en_i        (rd_en_i),
  .rd_data_o      (rd_data_o),
  .hv_enable_o    (hv_enable_o),
  .cmd_complete_o (cmd_complete_o)
);

// file: test/flash_command_sequencer_tb_top.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`include "flash_seq_defines.vh"
module flash_command_sequencer_tb_top;
  localparam int TICK = 200;
  reg         sys_clk_i;
  reg         rst_n_i;
  wire [15:0] addr_i;
  wire [7:0]  wr_data_i;
  wire        wr_en_i;
  wire        rd_en_i;
  wire [7:0]  rd_data_o;
  wire        hv_enable_o;
  wire        cmd_complete_o;
  int         num_errors = 0;
  int         checks = 0;
  int         hv_drops = 0;
  int         rises = 0;
  int         h;
  int         r;
  int         n;
  logic [7:0] cmds [3] = '{`CMD_PROG, `CMD_BURST, `CMD_MASS};
  // Sequencer with shortened erase counts
  flash_command_sequencer #(
    .PAGE_ERASE_TICKS (15'h0014),
    .MASS_ERASE_TICKS (15'h0028)
  ) DUT (
    .sys_clk_i      (sys_clk_i),
    .rst_n_i        (rst_n_i),
    .addr_i         (addr_i),
    .wr_data_i      (wr_data_i),
    .wr_en_i        (wr_en_i),
    .rd_en_i        (rd_en_i),
    .rd_data_o      (rd_data_o),
    .hv_enable_o    (hv_enable_o),
    .cmd_complete_o (cmd_complete_o)
  );
  host_bus_model host (
    .sys_clk_i (sys_clk_i),
    .addr_o    (addr_i),
    .wr_data_o (wr_data_i),
    .wr_en_o   (wr_en_i),
    .rd_en_o   (rd_en_i),
    .rd_data_i (rd_data_o)
  );
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  always @(negedge hv_enable_o) hv_drops++;
  always @(posedge cmd_complete_o) rises++;
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic rng(input int cyc, input int lo, input int hi);
    chk({7'h00, cyc >= lo && cyc <= hi}, 8'h01);
  endtask
  // Duration window for a count of whole ticks
  task automatic rtk(input int cyc, input int t);
    rng(cyc, (t - 1) * TICK - 4, t * TICK + 4);
  endtask
  task automatic wait_done(output int cyc);
    #1;
    cyc = 0;
    while (cmd_complete_o !== 1'b1 && cyc < 30000) begin
      @(posedge sys_clk_i);
      #1;
      cyc++;
    end
    if (cyc >= 30000) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic poll_empty();
    logic [7:0] d;
    d = 8'h00;
    for (int k = 0; k < 3000 && d[7] !== 1'b1; k++)
      host.rd(`ADDR_STAT, d);
    if (d[7] !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
  endtask
  initial begin
    rst_n_i = 1'b0;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk({7'h00, cmd_complete_o}, 8'h01);
    rchk(`ADDR_STAT, 8'hC0);
    rchk(16'h0010, 8'h00);
    host.wr(16'hF000, 8'h00);
    rchk(`ADDR_STAT, 8'hD0);
    host.wr(`ADDR_DIV, host.DIV_SET);
    rchk(`ADDR_DIV, 8'h00);
    host.wr(`ADDR_STAT, 8'h10);
    rchk(`ADDR_STAT, 8'hC0);
    host.wr(`ADDR_DIV, host.DIV_SET);
    host.wr(`ADDR_DIV, 8'h05);
    rchk(`ADDR_DIV, 8'hD8);
    host.wr(16'hF000, 8'h00);
    host.wr(`ADDR_CMD, 8'h33);
    rchk(`ADDR_STAT, 8'hD0);
    host.wr(`ADDR_STAT, 8'h10);
    host.seq(16'hF000, 8'h00, `CMD_MASS);
    wait_done(n);
    rtk(n, 40);
    host.seq(16'hF123, 8'h00, `CMD_VERIFY);
    wait_done(n);
    rng(n, 4096, 4110);
    rchk(`ADDR_STAT, 8'hC4);
    host.seq(16'hF100, 8'h5A, `CMD_PROG);
    host.wr(16'hF200, 8'h00);
    wait_done(n);
    rtk(n, 9);
    rchk(16'hF100, 8'h5A);
    rchk(`ADDR_STAT, 8'hD0);
    host.wr(`ADDR_STAT, 8'h10);
    host.seq(16'hF000, 8'h00, `CMD_VERIFY);
    wait_done(n);
    rng(n, 250, 300);
    rchk(`ADDR_STAT, 8'hC0);
    host.seq(16'hF300, 8'h3C, `CMD_PROG);
    wait_done(n);
    host.seq(16'hF1AB, 8'h99, `CMD_SECTOR);
    wait_done(n);
    rtk(n, 20);
    rchk(16'hF100, 8'hFF);
    rchk(16'hF300, 8'h3C);
    host.wr(`ADDR_PROT, 8'hFA);
    foreach (cmds[i]) begin
      host.seq(16'hFC00, 8'h00, cmds[i]);
      rchk(`ADDR_STAT, 8'hE0);
      host.wr(`ADDR_STAT, 8'h20);
    end
    host.wr(`ADDR_PROT, 8'hFF);
    h = hv_drops;
    r = rises;
    host.seq(16'hF400, 8'h11, `CMD_BURST);
    poll_empty();
    host.seq(16'hF000, 8'h22, `CMD_BURST);
    wait_done(n);
    rchk(16'hF400, 8'h11);
    rchk(16'hF401, 8'h22);
    chk(8'(hv_drops - h), 8'h01);
    chk(8'(rises - r), 8'h01);
    host.seq(16'hFFFF, 8'h77, `CMD_BURST);
    poll_empty();
    host.seq(16'hF000, 8'h88, `CMD_BURST);
    wait_done(n);
    rchk(`ADDR_STAT, 8'hD0);
    rchk(16'hFFFF, 8'h77);
    rchk(16'hF000, 8'hFF);
    wrap_up();
  end
endmodule
